// [hw/vcpu_if_pkg.sv]
package vcpu_if_pkg;

  // --------------------------------------------------------------------
  // register encodings (crn, crm, opc2)
  // --------------------------------------------------------------------
  localparam logic [3:0] ENC_CRN         = 4'hc;
  localparam logic [3:0] ENC_CRM         = 4'hc;
  localparam logic [2:0] ENC_OPC2_ACK1   = 3'h0;
  localparam logic [2:0] ENC_OPC2_G0EN   = 3'h6;
  localparam logic [2:0] ENC_OPC2_G1EN   = 3'h7;

  // --------------------------------------------------------------------
  // exception levels
  // --------------------------------------------------------------------
  localparam logic [1:0] LEVEL_EL0       = 2'h0;
  localparam logic [1:0] LEVEL_EL1       = 2'h1;
  localparam logic [1:0] LEVEL_EL2       = 2'h2;

  // --------------------------------------------------------------------
  // field layouts and reset values
  // --------------------------------------------------------------------
  localparam int          ENABLE_BIT     = 0;
  localparam int          ID_WIDTH       = 24;
  localparam int          DATA_WIDTH     = 32;
  localparam logic        ENABLE_RESET   = 1'b0;
  localparam logic [23:0] SPURIOUS_ID    = 24'h0003ff;
  localparam logic [23:0] NARROW_ID_MASK = 24'h00ffff;

  typedef enum logic [2:0] {
    OUT_VIRTUAL, OUT_PHYSICAL, OUT_NO_ACCESS, OUT_UNDEFINED,
    OUT_TRAP_EL1, OUT_TRAP_EL2, OUT_TRAP_HYP
  } outcome_t;

  typedef enum logic [1:0] {REG_ACK1, REG_G0EN, REG_G1EN, REG_NONE} target_t;

  typedef struct packed {
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  opc2;
    logic        write;
    logic [31:0] wdata;
    logic [1:0]  level;
    logic        non_secure;
    logic        tge;
  } sysreg_req_t;

  typedef struct packed {
    logic hyp_irq_routing_bit;
    logic hyp_fiq_routing_bit;
    logic sysreg_interface_enable;
    logic sysreg_interface_enable_el1;
    logic el2_implemented;
    logic el2_narrow;
    logic hyp_trap_c12;
    logic trap_all_group0;
    logic trap_all_group1;
    logic identifier_width_field;
    logic irqs_masked;
  } ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] interrupt_identifier;
    logic        group1;
    logic        signalable;
    logic        ackable;
  } pend_t;

endpackage : vcpu_if_pkg

// [hw/access_route.sv]
`timescale 1ns/1ns
module access_route (
  input  vcpu_if_pkg::sysreg_req_t req,
  input  vcpu_if_pkg::ctrl_t       ctrl,
  output vcpu_if_pkg::target_t     target,
  output vcpu_if_pkg::outcome_t    outcome
);

  // --------------------------------------------------------------------
  // encoding decode
  // --------------------------------------------------------------------
  always_comb begin
    target = vcpu_if_pkg::REG_NONE;
    if (req.crn == vcpu_if_pkg::ENC_CRN && req.crm == vcpu_if_pkg::ENC_CRM) begin
      if (req.opc2 == vcpu_if_pkg::ENC_OPC2_ACK1 && !req.write) begin
        target = vcpu_if_pkg::REG_ACK1;
      end else if (req.opc2 == vcpu_if_pkg::ENC_OPC2_G0EN) begin
        target = vcpu_if_pkg::REG_G0EN;
      end else if (req.opc2 == vcpu_if_pkg::ENC_OPC2_G1EN) begin
        target = vcpu_if_pkg::REG_G1EN;
      end
    end
  end

  // --------------------------------------------------------------------
  // routing and traps, highest priority first
  // --------------------------------------------------------------------
  always_comb begin
    logic group0;
    logic route;
    group0  = (target == vcpu_if_pkg::REG_G0EN);
    route   = group0 ? ctrl.hyp_fiq_routing_bit : ctrl.hyp_irq_routing_bit;
    outcome = vcpu_if_pkg::OUT_NO_ACCESS;
    if (target == vcpu_if_pkg::REG_NONE || req.level == vcpu_if_pkg::LEVEL_EL0) begin
      outcome = vcpu_if_pkg::OUT_NO_ACCESS;
    end else if (!req.non_secure) begin
      outcome = (req.level == vcpu_if_pkg::LEVEL_EL2) ? vcpu_if_pkg::OUT_NO_ACCESS
                                                      : vcpu_if_pkg::OUT_PHYSICAL;
    end else if (req.level != vcpu_if_pkg::LEVEL_EL1) begin
      outcome = vcpu_if_pkg::OUT_PHYSICAL;
    end else if (req.tge) begin
      outcome = vcpu_if_pkg::OUT_NO_ACCESS;
    end else if (!ctrl.sysreg_interface_enable) begin
      outcome = vcpu_if_pkg::OUT_UNDEFINED;
    end else if (!ctrl.sysreg_interface_enable_el1) begin
      outcome = vcpu_if_pkg::OUT_TRAP_EL1;
    end else if (ctrl.el2_implemented && ctrl.hyp_trap_c12) begin
      outcome = ctrl.el2_narrow ? vcpu_if_pkg::OUT_TRAP_HYP : vcpu_if_pkg::OUT_TRAP_EL2;
    end else if (group0 ? ctrl.trap_all_group0 : ctrl.trap_all_group1) begin
      outcome = vcpu_if_pkg::OUT_TRAP_EL2;
    end else if (route) begin
      outcome = vcpu_if_pkg::OUT_VIRTUAL;
    end else begin
      outcome = vcpu_if_pkg::OUT_PHYSICAL;
    end
  end

endmodule : access_route

// [hw/vcpu_sysreg_access.sv]
// Summary of operation
// - acknowledge read returns highest pending signalable, ackable virtual id and acknowledges it
// - identifier sits in bits 23:0, bits 31:24 read zero
// - unobservable pending interrupt reads as special identifier 1023 only
// - identifier is 16 or 24 bits wide; narrow form zeroes bits 23:16
// - masked acknowledge reads answer only after activation reaches exception signalling
// - irq routing bit clear sends non-secure EL1 acknowledge read to physical register
// - virtual acknowledge reachable read-only only at non-secure EL1 with irq routing set
// - interface enable clear makes EL1 reads undefined; EL1 enable clear traps to EL1
// - with EL2 present, c12 trap bit traps EL1 acknowledge reads to EL2 or Hyp
// - trap-all-group-one set traps non-secure EL1 acknowledge reads to EL2
// - group-zero enable is bit 0, other bits zero, resets to 0
// - group-zero enable virtual only with fiq routing set, else physical register
// - group-zero enable: undefined if interface disabled, EL2 trap on trap-all, EL2 or Hyp trap on c12
// - group-one enable is bit 0, other bits zero, resets to 0
// - group-one enable bit drives the group-one enabled output
`timescale 1ns/1ns
module vcpu_sysreg_access (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    req_valid,
  input  vcpu_if_pkg::sysreg_req_t     req,
  input  vcpu_if_pkg::ctrl_t           ctrl,
  input  vcpu_if_pkg::pend_t           pend,
  input  wire logic                    activation_seen,
  output logic                         req_ready,
  output logic                         resp_valid,
  output logic [31:0]                  resp_data,
  output vcpu_if_pkg::outcome_t        resp_outcome,
  output logic                         ack_valid,
  output logic [23:0]                  ack_id,
  output logic                         group0_enabled,
  output logic                         group1_enabled
);

  typedef enum logic {IDLE, SYNC} state_t;

  state_t                state;
  state_t                next_state;
  vcpu_if_pkg::target_t  target;
  vcpu_if_pkg::outcome_t outcome;
  logic                  group0_enable;
  logic                  group1_enable;
  logic                  accept;
  logic                  virt_access;
  logic                  take_ack;
  logic [23:0]           next_id;
  logic [31:0]           next_data;

  // --------------------------------------------------------------------
  // identifier selection
  // --------------------------------------------------------------------
  function automatic logic [23:0] ack_value(input vcpu_if_pkg::pend_t p, input logic g1_en,
                                            input logic wide);
    logic [23:0] id;
    id = vcpu_if_pkg::SPURIOUS_ID;
    if (p.valid && p.group1 && p.signalable && p.ackable && g1_en) begin
      id = p.interrupt_identifier;
    end
    if (!wide) begin
      id = id & vcpu_if_pkg::NARROW_ID_MASK;
    end
    return id;
  endfunction : ack_value

  function automatic logic [31:0] enable_word(input logic en);
    logic [31:0] w;
    w = '0;
    w[vcpu_if_pkg::ENABLE_BIT] = en;
    return w;
  endfunction : enable_word

  // --------------------------------------------------------------------
  // access decode
  // --------------------------------------------------------------------
  access_route u_route (
    .req     (req),
    .ctrl    (ctrl),
    .target  (target),
    .outcome (outcome)
  );

  assign accept      = req_valid && req_ready;
  assign virt_access = accept && outcome == vcpu_if_pkg::OUT_VIRTUAL;
  assign next_id     = ack_value(pend, group1_enable, ctrl.identifier_width_field);
  assign take_ack    = virt_access && target == vcpu_if_pkg::REG_ACK1 &&
                       next_id != vcpu_if_pkg::SPURIOUS_ID;

  always_comb begin
    next_data = '0;
    if (outcome == vcpu_if_pkg::OUT_VIRTUAL && !req.write) begin
      unique case (target)
        vcpu_if_pkg::REG_ACK1: next_data = {8'h00, next_id};
        vcpu_if_pkg::REG_G0EN: next_data = enable_word(group0_enable);
        vcpu_if_pkg::REG_G1EN: next_data = enable_word(group1_enable);
        default:               next_data = '0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // self-synchronising acknowledge
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (take_ack && ctrl.irqs_masked) begin
          next_state = SYNC;
        end
      end
      SYNC: begin
        if (activation_seen) begin
          next_state = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state     <= IDLE;
      req_ready <= 1'b0;
    end else begin
      state     <= next_state;
      req_ready <= (next_state == IDLE);
    end
  end

  // --------------------------------------------------------------------
  // response
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resp_valid   <= 1'b0;
      resp_data    <= '0;
      resp_outcome <= vcpu_if_pkg::OUT_NO_ACCESS;
    end else begin
      resp_valid <= 1'b0;
      if (accept) begin
        resp_data    <= next_data;
        resp_outcome <= outcome;
        resp_valid   <= !(take_ack && ctrl.irqs_masked);
      end else if (state == SYNC && activation_seen) begin
        resp_valid <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // acknowledge pulse
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_valid <= 1'b0;
      ack_id    <= '0;
    end else begin
      ack_valid <= take_ack;
      if (take_ack) begin
        ack_id <= next_id;
      end
    end
  end

  // --------------------------------------------------------------------
  // enable registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      group0_enable <= vcpu_if_pkg::ENABLE_RESET;
    end else if (virt_access && req.write && target == vcpu_if_pkg::REG_G0EN) begin
      group0_enable <= req.wdata[vcpu_if_pkg::ENABLE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      group1_enable <= vcpu_if_pkg::ENABLE_RESET;
    end else if (virt_access && req.write && target == vcpu_if_pkg::REG_G1EN) begin
      group1_enable <= req.wdata[vcpu_if_pkg::ENABLE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      group0_enabled <= vcpu_if_pkg::ENABLE_RESET;
      group1_enabled <= vcpu_if_pkg::ENABLE_RESET;
    end else begin
      group0_enabled <= group0_enable;
      group1_enabled <= group1_enable;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_masked_ack;
    take_ack && ctrl.irqs_masked;
  endsequence

  sequence s_sync_wait;
    !resp_valid && !req_ready;
  endsequence

  sequence s_ns_el1;
    accept && target != vcpu_if_pkg::REG_NONE && req.non_secure
    && req.level == vcpu_if_pkg::LEVEL_EL1 && !req.tge;
  endsequence

  sequence s_no_early_trap;
    ctrl.sysreg_interface_enable && ctrl.sysreg_interface_enable_el1
    && !(ctrl.el2_implemented && ctrl.hyp_trap_c12);
  endsequence

  a_ack_pulse_id: assert property (take_ack |=> ack_valid && ack_id == $past(next_id))
    else $error("acknowledge pulse or identifier wrong");
  a_ack_upper_zero: assert property (resp_valid |-> resp_data[31:24] == 8'h00)
    else $error("acknowledge upper bits not zero");
  a_spurious_no_ack: assert property (virt_access && target == vcpu_if_pkg::REG_ACK1 && !group1_enable
                                      |=> !ack_valid && resp_data[23:0] == vcpu_if_pkg::SPURIOUS_ID)
    else $error("disabled group acknowledged an interrupt");
  a_narrow_id: assert property (accept && !ctrl.identifier_width_field
                                |=> resp_data[23:16] == 8'h00)
    else $error("narrow identifier has upper bits set");
  a_sync_hold: assert property (s_masked_ack ##1 (!activation_seen)[*2]
                                |-> s_sync_wait)
    else $error("masked acknowledge answered before activation");
  a_sync_release: assert property (state == SYNC && activation_seen |=> resp_valid ##1 req_ready)
    else $error("acknowledge not released after activation");
  a_route_phys: assert property (accept && req.non_secure && req.level == vcpu_if_pkg::LEVEL_EL1 && !req.tge
                                 && outcome != vcpu_if_pkg::OUT_VIRTUAL |=> !ack_valid)
    else $error("non-virtual access acknowledged");
  a_undef_first: assert property (accept && target != vcpu_if_pkg::REG_NONE && req.non_secure
                                  && req.level == vcpu_if_pkg::LEVEL_EL1 && !req.tge
                                  && !ctrl.sysreg_interface_enable
                                  |=> resp_outcome == vcpu_if_pkg::OUT_UNDEFINED)
    else $error("disabled interface not undefined");
  a_g1_write: assert property (virt_access && req.write && target == vcpu_if_pkg::REG_G1EN
                               |=> ##1 group1_enabled == $past(req.wdata[vcpu_if_pkg::ENABLE_BIT], 2))
    else $error("group one enable not written");
  a_g0_hold: assert property (!(virt_access && req.write && target == vcpu_if_pkg::REG_G0EN)
                              |=> $stable(group0_enable))
    else $error("group zero enable changed without write");
  a_ack_data_match: assert property (ack_valid && resp_valid |-> resp_data[23:0] == ack_id)
    else $error("read data differs from acknowledged id");
  a_ack_not_spurious: assert property (ack_valid |-> ack_id != vcpu_if_pkg::SPURIOUS_ID)
    else $error("special identifier acknowledged");
  a_wide_id: assert property (
    take_ack && ctrl.identifier_width_field |=> ack_id == $past(pend.interrupt_identifier))
    else $error("wide identifier cut");
  a_masked_wait: assert property (s_masked_ack |=> s_sync_wait)
    else $error("masked acknowledge answered at once");
  a_sync_stays: assert property (state == SYNC && !activation_seen |=> state == SYNC && !req_ready)
    else $error("acknowledge released without activation");
  a_irq_route_off: assert property (
    s_ns_el1 ##0 s_no_early_trap ##0 (target == vcpu_if_pkg::REG_ACK1 && !ctrl.trap_all_group1
    && !ctrl.hyp_irq_routing_bit) |=> resp_outcome == vcpu_if_pkg::OUT_PHYSICAL && resp_data == 32'h0)
    else $error("acknowledge not sent to physical register");
  a_virt_only_el1: assert property (
    accept && outcome == vcpu_if_pkg::OUT_VIRTUAL
    |-> req.non_secure && req.level == vcpu_if_pkg::LEVEL_EL1 && !req.tge)
    else $error("virtual register reached outside non-secure el1");
  a_ack_read_only: assert property (accept && req.write |-> target != vcpu_if_pkg::REG_ACK1)
    else $error("acknowledge register written");
  a_trap_el1: assert property (
    s_ns_el1 ##0 (ctrl.sysreg_interface_enable && !ctrl.sysreg_interface_enable_el1)
    |=> resp_outcome == vcpu_if_pkg::OUT_TRAP_EL1)
    else $error("el1 trap missed");
  a_trap_c12: assert property (
    s_ns_el1 ##0 (ctrl.sysreg_interface_enable && ctrl.sysreg_interface_enable_el1)
    ##0 (ctrl.el2_implemented && ctrl.hyp_trap_c12)
    |=> resp_outcome == ($past(ctrl.el2_narrow) ? vcpu_if_pkg::OUT_TRAP_HYP : vcpu_if_pkg::OUT_TRAP_EL2))
    else $error("c12 trap missed");
  a_trap_all1: assert property (
    s_ns_el1 ##0 s_no_early_trap ##0 (ctrl.trap_all_group1 && target != vcpu_if_pkg::REG_G0EN)
    |=> resp_outcome == vcpu_if_pkg::OUT_TRAP_EL2)
    else $error("group one trap-all missed");
  a_trap_all0: assert property (
    s_ns_el1 ##0 s_no_early_trap ##0 (ctrl.trap_all_group0 && target == vcpu_if_pkg::REG_G0EN)
    |=> resp_outcome == vcpu_if_pkg::OUT_TRAP_EL2)
    else $error("group zero trap-all missed");
  a_fiq_route_off: assert property (
    s_ns_el1 ##0 s_no_early_trap ##0 (target == vcpu_if_pkg::REG_G0EN && !ctrl.trap_all_group0
    && !ctrl.hyp_fiq_routing_bit) |=> resp_outcome == vcpu_if_pkg::OUT_PHYSICAL)
    else $error("group zero enable not sent to physical register");
  a_enable_reserved: assert property (
    accept && outcome == vcpu_if_pkg::OUT_VIRTUAL && !req.write && target != vcpu_if_pkg::REG_ACK1
    |=> resp_data[31:1] == 31'h0)
    else $error("enable reserved bits not zero");
  a_g0_write: assert property (
    virt_access && req.write && target == vcpu_if_pkg::REG_G0EN
    |=> group0_enable == $past(req.wdata[vcpu_if_pkg::ENABLE_BIT]))
    else $error("group zero enable not written");
  a_g0_copy: assert property (group0_enabled == $past(group0_enable))
    else $error("group zero enabled output wrong");
  a_g1_hold: assert property (
    !(virt_access && req.write && target == vcpu_if_pkg::REG_G1EN) |=> $stable(group1_enable))
    else $error("group one enable changed without write");
  a_g1_copy: assert property (group1_enabled == $past(group1_enable))
    else $error("group one enabled output wrong");
  a_ack_needs_enable: assert property (ack_valid |-> group1_enabled)
    else $error("acknowledge while group one disabled");

endmodule : vcpu_sysreg_access

// [testbench/pe_activation_model.sv]
`timescale 1ns/1ns
// --------------------------------------------------------------------
// activation signalling of the priority logic beside the core
// --------------------------------------------------------------------
module pe_activation_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ack_valid,
  input  wire logic [3:0] delay,
  output logic            activation_seen
);
  logic [3:0] count;
  logic       running;

  // activation reaches exception signalling some cycles after the acknowledge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      running         <= 1'b0;
      count           <= 4'h0;
      activation_seen <= 1'b0;
    end else begin
      activation_seen <= 1'b0;
      if (ack_valid) begin
        running <= 1'b1;
        count   <= delay;
      end else if (running) begin
        if (count <= 4'h1) begin
          running         <= 1'b0;
          activation_seen <= 1'b1;
        end else begin
          count <= count - 4'h1;
        end
      end
    end
  end
endmodule : pe_activation_model

// [testbench/virt_cpu_if_ack_group_enable_test.sv]
`timescale 1ns/1ns
module virt_cpu_if_ack_group_enable_test;
  logic                    clock = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    req_valid = 1'b0;
  vcpu_if_pkg::sysreg_req_t req_i = '0;
  vcpu_if_pkg::ctrl_t      ctrl_i = '0;
  vcpu_if_pkg::pend_t      pend_i = '0;
  logic [3:0]              delay = 4'h1;
  logic                    activation_seen;
  logic                    req_ready, resp_valid, ack_valid, group0_enabled, group1_enabled;
  logic [31:0]             resp_data;
  vcpu_if_pkg::outcome_t   resp_outcome;
  logic [23:0]             ack_id;
  logic [31:0]             seed = 32'h0000004c;
  logic                    en0 = 1'b0;
  logic                    en1 = 1'b0;
  int                      n_errors = 0;
  int                      n_compared = 0;

  always #2 clock = ~clock;

  vcpu_sysreg_access i_dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req_i), .ctrl(ctrl_i),
    .pend(pend_i), .activation_seen(activation_seen), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_outcome(resp_outcome), .ack_valid(ack_valid), .ack_id(ack_id),
    .group0_enabled(group0_enabled), .group1_enabled(group1_enabled));
  pe_activation_model i_pe (.clock(clock), .rst_n(rst_n), .ack_valid(ack_valid), .delay(delay),
    .activation_seen(activation_seen));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic vcpu_if_pkg::outcome_t exp_oc(input vcpu_if_pkg::sysreg_req_t r, input vcpu_if_pkg::ctrl_t c);
    logic g0;
    logic dec;
    g0  = r.opc2 == vcpu_if_pkg::ENC_OPC2_G0EN;
    dec = r.crn == vcpu_if_pkg::ENC_CRN && r.crm == vcpu_if_pkg::ENC_CRM &&
          ((r.opc2 == vcpu_if_pkg::ENC_OPC2_ACK1 && !r.write) || g0 || r.opc2 == vcpu_if_pkg::ENC_OPC2_G1EN);
    if (!dec || r.level == vcpu_if_pkg::LEVEL_EL0) return vcpu_if_pkg::OUT_NO_ACCESS;
    if (!r.non_secure) return r.level == vcpu_if_pkg::LEVEL_EL2 ? vcpu_if_pkg::OUT_NO_ACCESS : vcpu_if_pkg::OUT_PHYSICAL;
    if (r.level != vcpu_if_pkg::LEVEL_EL1) return vcpu_if_pkg::OUT_PHYSICAL;
    if (r.tge) return vcpu_if_pkg::OUT_NO_ACCESS;
    if (!c.sysreg_interface_enable) return vcpu_if_pkg::OUT_UNDEFINED;
    if (!c.sysreg_interface_enable_el1) return vcpu_if_pkg::OUT_TRAP_EL1;
    if (c.el2_implemented && c.hyp_trap_c12) return c.el2_narrow ? vcpu_if_pkg::OUT_TRAP_HYP : vcpu_if_pkg::OUT_TRAP_EL2;
    if (g0 ? c.trap_all_group0 : c.trap_all_group1) return vcpu_if_pkg::OUT_TRAP_EL2;
    return (g0 ? c.hyp_fiq_routing_bit : c.hyp_irq_routing_bit) ? vcpu_if_pkg::OUT_VIRTUAL : vcpu_if_pkg::OUT_PHYSICAL;
  endfunction : exp_oc

  function automatic vcpu_if_pkg::sysreg_req_t mk(input logic [2:0] opc2, input logic wr);
    vcpu_if_pkg::sysreg_req_t r;
    r = '0;
    r.crn        = vcpu_if_pkg::ENC_CRN;
    r.crm        = vcpu_if_pkg::ENC_CRM;
    r.opc2       = opc2;
    r.write      = wr;
    r.wdata      = 32'hffffffff;
    r.level      = vcpu_if_pkg::LEVEL_EL1;
    r.non_secure = 1'b1;
    return r;
  endfunction : mk

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    n_compared++;
    if (seen !== expected) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // --------------------------------------------------------------------
  // one access with full comparison
  // --------------------------------------------------------------------
  task automatic run(input vcpu_if_pkg::sysreg_req_t r, input vcpu_if_pkg::ctrl_t c, input vcpu_if_pkg::pend_t p,
                     input logic [3:0] dly);
    vcpu_if_pkg::outcome_t eo;
    logic [23:0]           eid;
    logic                  real_ack;
    logic [31:0]           ed;
    logic                  saw;
    logic [23:0]           sid;
    int                    lat;
    eo       = exp_oc(r, c);
    eid      = c.identifier_width_field ? p.interrupt_identifier : p.interrupt_identifier & vcpu_if_pkg::NARROW_ID_MASK;
    real_ack = eo == vcpu_if_pkg::OUT_VIRTUAL && r.opc2 == vcpu_if_pkg::ENC_OPC2_ACK1 &&
               p.valid && p.group1 && p.signalable && p.ackable && en1;
    ed       = 32'h0;
    if (eo == vcpu_if_pkg::OUT_VIRTUAL && !r.write) begin
      if (r.opc2 == vcpu_if_pkg::ENC_OPC2_ACK1) ed = {8'h00, real_ack ? eid : vcpu_if_pkg::SPURIOUS_ID};
      else ed = {31'h0, r.opc2 == vcpu_if_pkg::ENC_OPC2_G0EN ? en0 : en1};
    end
    saw = 1'b0;
    sid = 24'h0;
    lat = 0;
    // let any earlier activation pulse die out
    repeat (8) @(posedge clock);
    #1;
    while (req_ready !== 1'b1 && lat < 50) begin
      @(posedge clock);
      #1;
      lat++;
    end
    check({31'h0, group0_enabled}, {31'h0, en0});
    check({31'h0, group1_enabled}, {31'h0, en1});
    req_i     = r;
    ctrl_i    = c;
    pend_i    = p;
    delay     = dly;
    req_valid = 1'b1;
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    req_i     = ~r;
    lat       = 1;
    forever begin
      if (ack_valid === 1'b1) begin
        saw = 1'b1;
        sid = ack_id;
      end
      if (resp_valid === 1'b1 || lat > 40) break;
      @(posedge clock);
      #1;
      lat++;
    end
    check(32'(resp_outcome), 32'(eo));
    check(resp_data, ed);
    check({31'h0, saw}, {31'h0, real_ack});
    if (real_ack) check({8'h00, sid}, {8'h00, eid});
    check(32'(lat), (real_ack && c.irqs_masked) ? 32'(dly) + 32'h3 : 32'h1);
    if (eo == vcpu_if_pkg::OUT_VIRTUAL && r.write && r.opc2 == vcpu_if_pkg::ENC_OPC2_G0EN) en0 = r.wdata[0];
    if (eo == vcpu_if_pkg::OUT_VIRTUAL && r.write && r.opc2 == vcpu_if_pkg::ENC_OPC2_G1EN) en1 = r.wdata[0];
  endtask : run

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    vcpu_if_pkg::ctrl_t       vc;
    vcpu_if_pkg::pend_t       vp;
    vcpu_if_pkg::sysreg_req_t r;
    logic [31:0]              a, b;
    logic [1:0]               sel;
    vc = '0;
    vc.hyp_irq_routing_bit = 1'b1;
    vc.hyp_fiq_routing_bit = 1'b1;
    vc.sysreg_interface_enable = 1'b1;
    vc.sysreg_interface_enable_el1 = 1'b1;
    vc.identifier_width_field = 1'b1;
    vp = '{valid: 1'b1, interrupt_identifier: 24'hffffff, group1: 1'b1, signalable: 1'b1, ackable: 1'b1};
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    run(mk(vcpu_if_pkg::ENC_OPC2_G0EN, 1'b0), vc, vp, 4'h1);
    run(mk(vcpu_if_pkg::ENC_OPC2_G1EN, 1'b0), vc, vp, 4'h1);
    run(mk(vcpu_if_pkg::ENC_OPC2_ACK1, 1'b0), vc, vp, 4'h1);
    run(mk(vcpu_if_pkg::ENC_OPC2_G1EN, 1'b1), vc, vp, 4'h1);
    run(mk(vcpu_if_pkg::ENC_OPC2_G0EN, 1'b1), vc, vp, 4'h1);
    run(mk(vcpu_if_pkg::ENC_OPC2_ACK1, 1'b0), vc, vp, 4'h1);
    vc.irqs_masked = 1'b1;
    run(mk(vcpu_if_pkg::ENC_OPC2_ACK1, 1'b0), vc, vp, 4'h6);
    for (int i = 0; i < 500; i++) begin
      a   = xs();
      b   = xs();
      sel = a[17:16];
      r   = mk(sel == 2'h0 ? vcpu_if_pkg::ENC_OPC2_ACK1 : sel == 2'h1 ? vcpu_if_pkg::ENC_OPC2_G0EN :
               sel == 2'h2 ? vcpu_if_pkg::ENC_OPC2_G1EN : b[6:4], a[18] & (sel != 2'h0 || a[19]));
      if (sel == 2'h3 && a[20]) r.crn = b[3:0];
      r.wdata      = b;
      r.level      = a[21] ? vcpu_if_pkg::LEVEL_EL1 : a[1:0];
      r.non_secure = |a[3:2];
      r.tge        = &a[5:4];
      vc = vcpu_if_pkg::ctrl_t'(11'(xs() & b[31:21]));
      vc.hyp_irq_routing_bit = |a[7:6];
      vc.hyp_fiq_routing_bit = |a[9:8];
      vc.sysreg_interface_enable = |a[11:10];
      vc.sysreg_interface_enable_el1 = |a[13:12];
      vc.identifier_width_field = a[14];
      vp = vcpu_if_pkg::pend_t'(28'(xs()));
      vp.group1 = vp.group1 | a[22];
      vp.signalable = vp.signalable | a[23];
      if (a[24]) vp.interrupt_identifier = 24'hffffff;
      if (vp.interrupt_identifier[15:0] == 16'h03ff) vp.interrupt_identifier[0] = 1'b0; // 1023 is never pending
      run(r, vc, vp, a[28] ? 4'h1 : 4'h6);
    end
    print_verdict();
  end

  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule : virt_cpu_if_ack_group_enable_test
